// *** hdl/codrs_defs.svh ***
// Behaviour
// - Opcodes x7 with high nibble 0-7 clear that memory bit; flags unchanged
// - Opcodes x7 with high nibble 8-F set bit (nibble minus eight); flags unchanged
// - Rotate left through carry, five modes; updates N, Z, C
// - Rotate right through carry, five modes; updates N, Z, C
// - Opcode 40 returns from interrupt, restoring N V D I Z C and PC
// - Opcode 60 returns from subroutine, reloading PC, flags unchanged
// - Subtract with borrow A minus M minus not C into A; updates N V Z C
// - Opcodes 38, F8, 78 set carry, decimal, interrupt-disable respectively
// - Store accumulator to effective address, eight modes, flags unchanged
// - Opcode DB holds phase-two clock high, halting until reset
// - Store X to memory, three modes, flags unchanged
`ifndef CODRS_DEFS_SVH
`define CODRS_DEFS_SVH

`define FLAG_N 7
`define FLAG_V 6
`define FLAG_Z 1
`define FLAG_C 0
`define MASK_NZC 8'h83
`define MASK_NVZC 8'hC3
`define MASK_RESTORE 8'hCF
`define MASK_C 8'h01
`define MASK_D 8'h08
`define MASK_I 8'h04
`define STATUS_RESET 8'h34

`define OPC_BIT_LOW 4'h7
`define BIT_SET_POS 7
`define BIT_SEL_HI 6
`define BIT_SEL_LO 4

`define OPC_ROTL_ABS 8'h2E
`define OPC_ROTL_ABSX 8'h3E
`define OPC_ROTL_ACC 8'h2A
`define OPC_ROTL_ZP 8'h26
`define OPC_ROTL_ZPX 8'h36
`define OPC_ROTR_ABS 8'h6E
`define OPC_ROTR_ABSX 8'h7E
`define OPC_ROTR_ACC 8'h6A
`define OPC_ROTR_ZP 8'h66
`define OPC_ROTR_ZPX 8'h76
`define OPC_IRET 8'h40
`define OPC_SRET 8'h60
`define OPC_SUBB_ABS 8'hED
`define OPC_SUBB_ABSX 8'hFD
`define OPC_SUBB_ABSY 8'hF9
`define OPC_SUBB_IMM 8'hE9
`define OPC_SUBB_ZP 8'hE5
`define OPC_SUBB_ZPXI 8'hE1
`define OPC_SUBB_ZPX 8'hF5
`define OPC_SUBB_ZPI 8'hF2
`define OPC_SUBB_ZPIY 8'hF1
`define OPC_SETC 8'h38
`define OPC_SETD 8'hF8
`define OPC_SETI 8'h78
`define OPC_STACC_ABS 8'h8D
`define OPC_STACC_ABSX 8'h9D
`define OPC_STACC_ABSY 8'h99
`define OPC_STACC_ZP 8'h85
`define OPC_STACC_ZPXI 8'h81
`define OPC_STACC_ZPX 8'h95
`define OPC_STACC_ZPI 8'h92
`define OPC_STACC_ZPIY 8'h91
`define OPC_HALT 8'hDB
`define OPC_STIX_ABS 8'h8E
`define OPC_STIX_ZP 8'h86
`define OPC_STIX_ZPY 8'h96

`endif

// *** hdl/codrs_pkg.sv ***
`default_nettype none
package codrs_pkg;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_CLRBIT = 4'h1,
    OP_SETBIT = 4'h2,
    OP_ROTL   = 4'h3,
    OP_ROTR   = 4'h4,
    OP_IRET   = 4'h5,
    OP_SRET   = 4'h6,
    OP_SUBB   = 4'h7,
    OP_SETC   = 4'h8,
    OP_SETD   = 4'h9,
    OP_SETI   = 4'hA,
    OP_STACC  = 4'hB,
    OP_STIX   = 4'hC,
    OP_HALT   = 4'hD
  } codrs_op_t;

  typedef enum logic [3:0] {
    MODE_IMPLIED = 4'h0,
    MODE_STACK   = 4'h1,
    MODE_ACC     = 4'h2,
    MODE_IMM     = 4'h3,
    MODE_ABS     = 4'h4,
    MODE_ABS_X   = 4'h5,
    MODE_ABS_Y   = 4'h6,
    MODE_ZP      = 4'h7,
    MODE_ZP_X    = 4'h8,
    MODE_ZP_Y    = 4'h9,
    MODE_ZP_IND  = 4'hA,
    MODE_ZP_X_IND = 4'hB,
    MODE_ZP_IND_Y = 4'hC
  } codrs_mode_t;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b01,
    ST_STOPPED = 2'b10
  } codrs_state_t;

endpackage
`default_nettype wire

// *** hdl/codrs_shift_unit.sv ***
`include "codrs_defs.svh"
`default_nettype none
module codrs_shift_unit (
  // Operation
  input  wire codrs_pkg::codrs_op_t op_in,
  input  wire logic [2:0]           bit_sel_in,
  // Data
  input  wire logic [7:0]           data_in,
  input  wire logic                 carry_in,
  output logic      [7:0]           data_out,
  output logic                      carry_out
);

  always_comb begin
    data_out = data_in;
    carry_out = carry_in;
    case (op_in)
      codrs_pkg::OP_CLRBIT: data_out[bit_sel_in] = 1'b0;
      codrs_pkg::OP_SETBIT: data_out[bit_sel_in] = 1'b1;
      codrs_pkg::OP_ROTL: begin
        data_out = {data_in[6:0], carry_in};
        carry_out = data_in[7];
      end
      codrs_pkg::OP_ROTR: begin
        data_out = {carry_in, data_in[7:1]};
        carry_out = data_in[0];
      end
      default: data_out = data_in;
    endcase
  end

endmodule
`default_nettype wire

// *** hdl/codrs_sub_unit.sv ***
`default_nettype none
module codrs_sub_unit (
  // Operands
  input  wire logic [7:0] acc_in,
  input  wire logic [7:0] operand_in,
  input  wire logic       carry_in,
  // Result
  output logic      [7:0] diff_out,
  output logic            carry_out,
  output logic            overflow_out
);

  logic [8:0] wide;

  always_comb begin
    wide = {1'b0, acc_in} - {1'b0, operand_in} - {8'h00, ~carry_in};
    diff_out = wide[7:0];
    carry_out = ~wide[8];
    overflow_out = (acc_in[7] ^ operand_in[7]) & (acc_in[7] ^ wide[7]);
  end

endmodule
`default_nettype wire

// *** hdl/codrs_exec.sv ***
`include "codrs_defs.svh"
`default_nettype none
module codrs_exec (
  // Clock, reset, enable
  input  wire logic                  mclk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  clk_en_in,
  // Instruction and operands
  input  wire logic                  instr_valid_in,
  input  wire logic [7:0]            opcode_in,
  input  wire logic [7:0]            operand_in,
  input  wire logic [7:0]            acc_in,
  input  wire logic [7:0]            index_x_in,
  input  wire logic [7:0]            pulled_status_in,
  // Decode results
  output logic                       done_out,
  output var codrs_pkg::codrs_op_t   op_out,
  output var codrs_pkg::codrs_mode_t mode_out,
  output logic      [2:0]            bit_sel_out,
  output logic                       unknown_op_out,
  // Execute results
  output logic      [7:0]            result_out,
  output logic                       mem_write_out,
  output logic                       acc_write_out,
  output logic                       pc_pull_out,
  output logic      [7:0]            status_out,
  output logic                       phase_two_clock_held_out
);

  codrs_pkg::codrs_op_t    dec_op;
  codrs_pkg::codrs_mode_t  dec_mode;
  codrs_pkg::codrs_state_t state_q;
  logic [7:0]              dec_mask;
  logic [2:0]              bit_sel;
  logic [7:0]              shift_src;
  logic [7:0]              shift_res;
  logic                    shift_c;
  logic [7:0]              sub_res;
  logic                    sub_c;
  logic                    sub_v;
  logic [7:0]              new_flags;
  logic [7:0]              status_d;
  logic [7:0]              result_d;
  logic                    accept;
  logic                    take;

  function automatic logic [7:0] nz_flags(input logic [7:0] v);
    logic [7:0] f;
    f = 8'h00;
    f[`FLAG_N] = v[7];
    f[`FLAG_Z] = (v == 8'h00);
    return f;
  endfunction

  // Instructions after a stop are ignored until reset
  assign accept = instr_valid_in & (state_q == codrs_pkg::ST_RUN);
  assign take = clk_en_in & accept;
  assign bit_sel = opcode_in[`BIT_SEL_HI:`BIT_SEL_LO];

  always_comb begin
    dec_op = codrs_pkg::OP_NONE;
    if (opcode_in[3:0] == `OPC_BIT_LOW) begin
      dec_op = opcode_in[`BIT_SET_POS] ? codrs_pkg::OP_SETBIT : codrs_pkg::OP_CLRBIT;
    end else begin
      case (opcode_in)
        `OPC_ROTL_ABS, `OPC_ROTL_ABSX, `OPC_ROTL_ACC, `OPC_ROTL_ZP,
        `OPC_ROTL_ZPX: dec_op = codrs_pkg::OP_ROTL;
        `OPC_ROTR_ABS, `OPC_ROTR_ABSX, `OPC_ROTR_ACC, `OPC_ROTR_ZP,
        `OPC_ROTR_ZPX: dec_op = codrs_pkg::OP_ROTR;
        `OPC_IRET: dec_op = codrs_pkg::OP_IRET;
        `OPC_SRET: dec_op = codrs_pkg::OP_SRET;
        `OPC_SUBB_ABS, `OPC_SUBB_ABSX, `OPC_SUBB_ABSY, `OPC_SUBB_IMM,
        `OPC_SUBB_ZP, `OPC_SUBB_ZPXI, `OPC_SUBB_ZPX, `OPC_SUBB_ZPI,
        `OPC_SUBB_ZPIY: dec_op = codrs_pkg::OP_SUBB;
        `OPC_SETC: dec_op = codrs_pkg::OP_SETC;
        `OPC_SETD: dec_op = codrs_pkg::OP_SETD;
        `OPC_SETI: dec_op = codrs_pkg::OP_SETI;
        `OPC_STACC_ABS, `OPC_STACC_ABSX, `OPC_STACC_ABSY, `OPC_STACC_ZP,
        `OPC_STACC_ZPXI, `OPC_STACC_ZPX, `OPC_STACC_ZPI,
        `OPC_STACC_ZPIY: dec_op = codrs_pkg::OP_STACC;
        `OPC_HALT: dec_op = codrs_pkg::OP_HALT;
        `OPC_STIX_ABS, `OPC_STIX_ZP,
        `OPC_STIX_ZPY: dec_op = codrs_pkg::OP_STIX;
        default: dec_op = codrs_pkg::OP_NONE;
      endcase
    end
  end

  always_comb begin
    dec_mode = codrs_pkg::MODE_IMPLIED;
    if (opcode_in[3:0] == `OPC_BIT_LOW) begin
      dec_mode = codrs_pkg::MODE_ZP;
    end else begin
      case (opcode_in)
        `OPC_ROTL_ABS, `OPC_ROTR_ABS, `OPC_SUBB_ABS, `OPC_STACC_ABS,
        `OPC_STIX_ABS: dec_mode = codrs_pkg::MODE_ABS;
        `OPC_ROTL_ABSX, `OPC_ROTR_ABSX, `OPC_SUBB_ABSX,
        `OPC_STACC_ABSX: dec_mode = codrs_pkg::MODE_ABS_X;
        `OPC_SUBB_ABSY, `OPC_STACC_ABSY: dec_mode = codrs_pkg::MODE_ABS_Y;
        `OPC_ROTL_ACC, `OPC_ROTR_ACC: dec_mode = codrs_pkg::MODE_ACC;
        `OPC_SUBB_IMM: dec_mode = codrs_pkg::MODE_IMM;
        `OPC_ROTL_ZP, `OPC_ROTR_ZP, `OPC_SUBB_ZP, `OPC_STACC_ZP,
        `OPC_STIX_ZP: dec_mode = codrs_pkg::MODE_ZP;
        `OPC_ROTL_ZPX, `OPC_ROTR_ZPX, `OPC_SUBB_ZPX,
        `OPC_STACC_ZPX: dec_mode = codrs_pkg::MODE_ZP_X;
        `OPC_STIX_ZPY: dec_mode = codrs_pkg::MODE_ZP_Y;
        `OPC_SUBB_ZPI, `OPC_STACC_ZPI: dec_mode = codrs_pkg::MODE_ZP_IND;
        `OPC_SUBB_ZPXI, `OPC_STACC_ZPXI: dec_mode = codrs_pkg::MODE_ZP_X_IND;
        `OPC_SUBB_ZPIY, `OPC_STACC_ZPIY: dec_mode = codrs_pkg::MODE_ZP_IND_Y;
        `OPC_IRET, `OPC_SRET: dec_mode = codrs_pkg::MODE_STACK;
        default: dec_mode = codrs_pkg::MODE_IMPLIED;
      endcase
    end
  end

  // Which flags each operation may touch
  always_comb begin
    case (dec_op)
      codrs_pkg::OP_ROTL,
      codrs_pkg::OP_ROTR: dec_mask = `MASK_NZC;
      codrs_pkg::OP_IRET: dec_mask = `MASK_RESTORE;
      codrs_pkg::OP_SUBB: dec_mask = `MASK_NVZC;
      codrs_pkg::OP_SETC: dec_mask = `MASK_C;
      codrs_pkg::OP_SETD: dec_mask = `MASK_D;
      codrs_pkg::OP_SETI: dec_mask = `MASK_I;
      default: dec_mask = 8'h00;
    endcase
  end

  assign shift_src = (dec_mode == codrs_pkg::MODE_ACC) ? acc_in : operand_in;

  codrs_shift_unit u_shift (
    .op_in      (dec_op),
    .bit_sel_in (bit_sel),
    .data_in    (shift_src),
    .carry_in   (status_out[`FLAG_C]),
    .data_out   (shift_res),
    .carry_out  (shift_c)
  );

  codrs_sub_unit u_sub (
    .acc_in       (acc_in),
    .operand_in   (operand_in),
    .carry_in     (status_out[`FLAG_C]),
    .diff_out     (sub_res),
    .carry_out    (sub_c),
    .overflow_out (sub_v)
  );

  always_comb begin
    new_flags = 8'hFF;
    case (dec_op)
      codrs_pkg::OP_ROTL,
      codrs_pkg::OP_ROTR: begin
        new_flags = nz_flags(shift_res);
        new_flags[`FLAG_C] = shift_c;
      end
      codrs_pkg::OP_SUBB: begin
        new_flags = nz_flags(sub_res);
        new_flags[`FLAG_V] = sub_v;
        new_flags[`FLAG_C] = sub_c;
      end
      codrs_pkg::OP_IRET: new_flags = pulled_status_in;
      default: new_flags = 8'hFF;
    endcase
  end

  assign status_d = (status_out & ~dec_mask) | (new_flags & dec_mask);

  always_comb begin
    case (dec_op)
      codrs_pkg::OP_CLRBIT,
      codrs_pkg::OP_SETBIT,
      codrs_pkg::OP_ROTL,
      codrs_pkg::OP_ROTR: result_d = shift_res;
      codrs_pkg::OP_SUBB: result_d = sub_res;
      codrs_pkg::OP_STACC: result_d = acc_in;
      codrs_pkg::OP_STIX: result_d = index_x_in;
      default: result_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_q <= codrs_pkg::ST_RUN;
      phase_two_clock_held_out <= 1'b0;
    end else if (take && dec_op == codrs_pkg::OP_HALT) begin
      state_q <= codrs_pkg::ST_STOPPED;
      phase_two_clock_held_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      status_out <= `STATUS_RESET;
    end else if (take) begin
      status_out <= status_d;
    end
  end

  // Strobes freeze with the clock enable rather than drop
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
      mem_write_out <= 1'b0;
      acc_write_out <= 1'b0;
      pc_pull_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= accept;
      mem_write_out <= accept & ((dec_op == codrs_pkg::OP_CLRBIT) |
                                 (dec_op == codrs_pkg::OP_SETBIT) |
                                 (dec_op == codrs_pkg::OP_STACC) |
                                 (dec_op == codrs_pkg::OP_STIX) |
                                 (((dec_op == codrs_pkg::OP_ROTL) |
                                   (dec_op == codrs_pkg::OP_ROTR)) &
                                  (dec_mode != codrs_pkg::MODE_ACC)));
      acc_write_out <= accept & ((dec_op == codrs_pkg::OP_SUBB) |
                                 (((dec_op == codrs_pkg::OP_ROTL) |
                                   (dec_op == codrs_pkg::OP_ROTR)) &
                                  (dec_mode == codrs_pkg::MODE_ACC)));
      pc_pull_out <= accept & ((dec_op == codrs_pkg::OP_IRET) |
                               (dec_op == codrs_pkg::OP_SRET));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      op_out <= codrs_pkg::OP_NONE;
      mode_out <= codrs_pkg::MODE_IMPLIED;
      bit_sel_out <= 3'h0;
      unknown_op_out <= 1'b0;
      result_out <= 8'h00;
    end else if (take) begin
      op_out <= dec_op;
      mode_out <= dec_mode;
      bit_sel_out <= bit_sel;
      unknown_op_out <= (dec_op == codrs_pkg::OP_NONE);
      result_out <= result_d;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  bit_clear_a: assert property (
    take && dec_op == codrs_pkg::OP_CLRBIT |=>
      result_out == ($past(operand_in) & ~(8'h01 << $past(bit_sel))) &&
      status_out == $past(status_out) && mem_write_out)
    else $error("memory bit clear wrong");

  bit_set_a: assert property (
    take && dec_op == codrs_pkg::OP_SETBIT |=>
      result_out == ($past(operand_in) | (8'h01 << $past(bit_sel))) &&
      status_out == $past(status_out) && mem_write_out)
    else $error("memory bit set wrong");

  rotate_left_a: assert property (
    take && dec_op == codrs_pkg::OP_ROTL && dec_mode == codrs_pkg::MODE_ACC |=>
      result_out == {$past(acc_in[6:0]), $past(status_out[`FLAG_C])} &&
      status_out[`FLAG_C] == $past(acc_in[7]) && acc_write_out && !mem_write_out)
    else $error("rotate left wrong");

  rotate_right_a: assert property (
    take && dec_op == codrs_pkg::OP_ROTR && dec_mode != codrs_pkg::MODE_ACC |=>
      result_out == {$past(status_out[`FLAG_C]), $past(operand_in[7:1])} &&
      status_out[`FLAG_C] == $past(operand_in[0]) &&
      status_out[`FLAG_N] == $past(status_out[`FLAG_C]) && mem_write_out)
    else $error("rotate right wrong");

  irq_return_a: assert property (
    take && dec_op == codrs_pkg::OP_IRET |=>
      (status_out & `MASK_RESTORE) == ($past(pulled_status_in) & `MASK_RESTORE) &&
      status_out[5:4] == $past(status_out[5:4]) && pc_pull_out)
    else $error("interrupt return status wrong");

  sub_return_a: assert property (
    take && dec_op == codrs_pkg::OP_SRET |=>
      pc_pull_out && status_out == $past(status_out) && !mem_write_out)
    else $error("subroutine return touched flags");

  sub_borrow_a: assert property (
    take && dec_op == codrs_pkg::OP_SUBB |=>
      result_out == 8'($past(acc_in) - $past(operand_in) -
                       {7'h00, ~$past(status_out[`FLAG_C])}) &&
      acc_write_out && status_out[`FLAG_Z] == (result_out == 8'h00))
    else $error("subtract with borrow wrong");

  flag_set_a: assert property (
    take && (dec_op == codrs_pkg::OP_SETC || dec_op == codrs_pkg::OP_SETD ||
             dec_op == codrs_pkg::OP_SETI) |=>
      status_out == ($past(status_out) |
                     (($past(opcode_in) == `OPC_SETC) ? `MASK_C :
                      ($past(opcode_in) == `OPC_SETD) ? `MASK_D : `MASK_I)))
    else $error("flag set wrong");

  store_acc_a: assert property (
    take && dec_op == codrs_pkg::OP_STACC |=>
      mem_write_out && result_out == $past(acc_in) && status_out == $past(status_out))
    else $error("accumulator store wrong");

  stop_hold_a: assert property (
    take && dec_op == codrs_pkg::OP_HALT |=>
      phase_two_clock_held_out ##1 phase_two_clock_held_out && !(done_out && $past(clk_en_in)))
    else $error("stop did not hold clock");

  store_x_a: assert property (
    take && dec_op == codrs_pkg::OP_STIX |=>
      mem_write_out && result_out == $past(index_x_in) && status_out == $past(status_out))
    else $error("index store wrong");

  flag_keep_a: assert property (
    take |=> (status_out & ~$past(dec_mask)) == ($past(status_out) & ~$past(dec_mask)))
    else $error("unaffected flag changed");

  flag_still_a: assert property (
    take && dec_op inside {codrs_pkg::OP_CLRBIT, codrs_pkg::OP_SETBIT,
                           codrs_pkg::OP_SRET, codrs_pkg::OP_NONE} |=>
      status_out == $past(status_out))
    else $error("flag free operation changed flags");

  stop_seen_c: cover property (take && dec_op == codrs_pkg::OP_HALT);
  borrow_seen_c: cover property (take && dec_op == codrs_pkg::OP_SUBB && !sub_c);
  restore_seen_c: cover property (take && dec_op == codrs_pkg::OP_IRET);
  stall_seen_c: cover property (instr_valid_in && !clk_en_in ##1 take);

endmodule
`default_nettype wire

// *** testbench/codrs_mem_model.sv ***
`default_nettype none
module codrs_mem_model (
  // Clock and enable
  input  wire logic       mclk_in,
  input  wire logic       clk_en_in,
  // Read side
  input  wire logic [7:0] addr_in,
  output logic      [7:0] rd_data_out,
  output logic      [7:0] stack_data_out,
  // Write side
  input  wire logic       mem_write_in,
  input  wire logic [7:0] wr_data_in,
  output logic      [7:0] last_wr_out,
  output int              wr_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem_q [256];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = 8'(i * 37 + 11);
    end
    wr_cnt_out = 0;
    last_wr_out = 8'h00;
  end

  // Stack byte from the mirrored address, so it differs from the operand
  assign rd_data_out    = mem_q[addr_in];
  assign stack_data_out = mem_q[~addr_in];

  // Writes go to a log only, keeping operand reads predictable
  always @(posedge mclk_in) begin
    if (mem_write_in === 1'b1 && clk_en_in === 1'b1) begin
      wr_cnt_out <= wr_cnt_out + 1;
      last_wr_out <= wr_data_in;
    end
  end
endmodule
`default_nettype wire

// *** testbench/codrs_exec_bench.sv ***
`default_nettype none
module codrs_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] OPL [38] = '{
    8'h2E, 8'h3E, 8'h2A, 8'h26, 8'h36, 8'h6E, 8'h7E, 8'h6A, 8'h66, 8'h76,
    8'h40, 8'h60, 8'hED, 8'hFD, 8'hF9, 8'hE9, 8'hE5, 8'hE1, 8'hF5, 8'hF2,
    8'hF1, 8'h38, 8'hF8, 8'h78, 8'h8D, 8'h9D, 8'h99, 8'h85, 8'h81, 8'h95,
    8'h92, 8'h91, 8'h8E, 8'h86, 8'h96, 8'h02, 8'hEA, 8'h03};

  logic                 mclk_in        = 1'b0;
  logic                 reset_n_in     = 1'b0;
  logic                 clk_en_in      = 1'b1;
  logic                 instr_valid_in = 1'b0;
  logic [7:0]           opcode_in      = 8'h00;
  logic [7:0]           acc_in         = 8'h00;
  logic [7:0]           index_x_in     = 8'h00;
  logic [7:0]           addr           = 8'h00;
  logic                 en_q           = 1'b0;
  logic [7:0]           exp_st         = 8'h34;
  logic [26:0]          exp_q [$];
  codrs_pkg::codrs_mode_t exp_m_q [$];
  logic [7:0]           exp_last       = 8'h00;
  wire  [7:0]           operand_w;
  wire  [7:0]           pulled_w;
  wire  [7:0]           last_wr;
  int                   wr_cnt;
  int                   exp_wr         = 0;
  int                   error_cnt      = 0;
  int                   compares       = 0;
  int                   cycles         = 0;
  logic                 done_out;
  codrs_pkg::codrs_op_t op_out;
  codrs_pkg::codrs_mode_t mode_out;
  logic [2:0]           bit_sel_out;
  logic                 unknown_op_out;
  logic [7:0]           result_out;
  logic                 mem_write_out;
  logic                 acc_write_out;
  logic                 pc_pull_out;
  logic [7:0]           status_out;
  logic                 phase_two_clock_held_out;

  always #5 mclk_in = ~mclk_in;

  codrs_exec codrs_exec_inst (
    .mclk_in                  (mclk_in),
    .reset_n_in               (reset_n_in),
    .clk_en_in                (clk_en_in),
    .instr_valid_in           (instr_valid_in),
    .opcode_in                (opcode_in),
    .operand_in               (operand_w),
    .acc_in                   (acc_in),
    .index_x_in               (index_x_in),
    .pulled_status_in         (pulled_w),
    .done_out                 (done_out),
    .op_out                   (op_out),
    .mode_out                 (mode_out),
    .bit_sel_out              (bit_sel_out),
    .unknown_op_out           (unknown_op_out),
    .result_out               (result_out),
    .mem_write_out            (mem_write_out),
    .acc_write_out            (acc_write_out),
    .pc_pull_out              (pc_pull_out),
    .status_out               (status_out),
    .phase_two_clock_held_out (phase_two_clock_held_out)
  );

  codrs_mem_model codrs_mem_model_inst (
    .mclk_in        (mclk_in),
    .clk_en_in      (clk_en_in),
    .addr_in        (addr),
    .rd_data_out    (operand_w),
    .stack_data_out (pulled_w),
    .mem_write_in   (mem_write_out),
    .wr_data_in     (result_out),
    .last_wr_out    (last_wr),
    .wr_cnt_out     (wr_cnt)
  );

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [26:0] got, input logic [26:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Packs op, result, status, write strobes, unknown flag and bit select
  function automatic logic [26:0] predict(input logic [7:0] opc, opd, acc, x, pul,
                                          inout logic [7:0] st);
    codrs_pkg::codrs_op_t op;
    logic [7:0]           r;
    logic [7:0]           src;
    logic [8:0]           d;
    logic                 mw;
    logic                 aw;
    logic                 pp;
    logic                 unk;
    op = codrs_pkg::OP_NONE;
    r = 8'h00;
    {mw, aw, pp, unk} = 4'h0;
    src = (opc[3:0] == 4'hA) ? acc : opd;
    if (opc[3:0] == 4'h7) begin
      op = opc[7] ? codrs_pkg::OP_SETBIT : codrs_pkg::OP_CLRBIT;
      r = opc[7] ? (opd | (8'h01 << opc[6:4])) : (opd & ~(8'h01 << opc[6:4]));
      mw = 1'b1;
    end else begin
      case (opc)
        8'h2E, 8'h3E, 8'h2A, 8'h26, 8'h36: begin
          op = codrs_pkg::OP_ROTL;
          r = {src[6:0], st[0]};
          st[0] = src[7];
        end
        8'h6E, 8'h7E, 8'h6A, 8'h66, 8'h76: begin
          op = codrs_pkg::OP_ROTR;
          r = {st[0], src[7:1]};
          st[0] = src[0];
        end
        8'h40: begin
          op = codrs_pkg::OP_IRET;
          pp = 1'b1;
          st = (pul & 8'hCF) | (st & 8'h30);
        end
        8'h60: begin
          op = codrs_pkg::OP_SRET;
          pp = 1'b1;
        end
        8'hED, 8'hFD, 8'hF9, 8'hE9, 8'hE5, 8'hE1, 8'hF5, 8'hF2, 8'hF1: begin
          op = codrs_pkg::OP_SUBB;
          d = {1'b0, acc} - {1'b0, opd} - {8'h00, ~st[0]};
          r = d[7:0];
          st[0] = ~d[8];
          st[6] = (acc[7] ^ opd[7]) & (acc[7] ^ r[7]);
          aw = 1'b1;
        end
        8'h38: begin
          op = codrs_pkg::OP_SETC;
          st[0] = 1'b1;
        end
        8'hF8: begin
          op = codrs_pkg::OP_SETD;
          st[3] = 1'b1;
        end
        8'h78: begin
          op = codrs_pkg::OP_SETI;
          st[2] = 1'b1;
        end
        8'h8D, 8'h9D, 8'h99, 8'h85, 8'h81, 8'h95, 8'h92, 8'h91: begin
          op = codrs_pkg::OP_STACC;
          r = acc;
          mw = 1'b1;
        end
        8'h8E, 8'h86, 8'h96: begin
          op = codrs_pkg::OP_STIX;
          r = x;
          mw = 1'b1;
        end
        8'hDB: op = codrs_pkg::OP_HALT;
        default: unk = 1'b1;
      endcase
    end
    if (op inside {codrs_pkg::OP_ROTL, codrs_pkg::OP_ROTR}) begin
      {aw, mw} = (opc[3:0] == 4'hA) ? 2'b10 : 2'b01;
    end
    if (op inside {codrs_pkg::OP_ROTL, codrs_pkg::OP_ROTR, codrs_pkg::OP_SUBB}) begin
      st[7] = r[7];
      st[1] = (r == 8'h00);
    end
    return {op, r, st, mw, aw, pp, unk, opc[6:4]};
  endfunction

  function automatic codrs_pkg::codrs_mode_t mode_of(input logic [7:0] opc);
    if (opc[3:0] == 4'h7) return codrs_pkg::MODE_ZP;
    case (opc)
      8'h2E, 8'h6E, 8'hED, 8'h8D, 8'h8E: return codrs_pkg::MODE_ABS;
      8'h3E, 8'h7E, 8'hFD, 8'h9D: return codrs_pkg::MODE_ABS_X;
      8'hF9, 8'h99: return codrs_pkg::MODE_ABS_Y;
      8'h2A, 8'h6A: return codrs_pkg::MODE_ACC;
      8'hE9: return codrs_pkg::MODE_IMM;
      8'h26, 8'h66, 8'hE5, 8'h85, 8'h86: return codrs_pkg::MODE_ZP;
      8'h36, 8'h76, 8'hF5, 8'h95: return codrs_pkg::MODE_ZP_X;
      8'h96: return codrs_pkg::MODE_ZP_Y;
      8'hF2, 8'h92: return codrs_pkg::MODE_ZP_IND;
      8'hE1, 8'h81: return codrs_pkg::MODE_ZP_X_IND;
      8'hF1, 8'h91: return codrs_pkg::MODE_ZP_IND_Y;
      8'h40, 8'h60: return codrs_pkg::MODE_STACK;
      default: return codrs_pkg::MODE_IMPLIED;
    endcase
  endfunction

  // Random enable gaps; the note is queued once the opcode is really taken
  task automatic issue(input logic [7:0] opc, input bit expect_it);
    logic [7:0]  a;
    logic [7:0]  ac;
    logic [7:0]  xv;
    logic [26:0] v;
    bit          en;
    a = 8'($urandom);
    ac = 8'($urandom);
    xv = 8'($urandom);
    do begin
      @(posedge mclk_in);
      en = ($urandom % 4) != 0;
      clk_en_in <= en;
      instr_valid_in <= 1'b1;
      opcode_in <= opc;
      addr <= a;
      acc_in <= ac;
      index_x_in <= xv;
    end while (!en);
    if (expect_it) begin
      v = predict(opc, 8'(a * 37 + 11), ac, xv, 8'((~a) * 37 + 11), exp_st);
      exp_q.push_back(v);
      exp_m_q.push_back(mode_of(opc));
      exp_wr += v[6];
      if (v[6]) exp_last = v[22:15];
    end
  endtask

  task automatic idle();
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    clk_en_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask

  always @(posedge mclk_in) en_q <= clk_en_in;

  // A frozen done under a low enable is the same result, not a new one
  always @(posedge mclk_in) begin
    #1;
    if (reset_n_in === 1'b1 && done_out === 1'b1 && en_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(27'h1, 27'h0);
      end else begin
        check({op_out, result_out, status_out, mem_write_out, acc_write_out,
               pc_pull_out, unknown_op_out, bit_sel_out}, exp_q.pop_front());
        check(27'(mode_out), 27'(exp_m_q.pop_front()));
      end
    end
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("timeout at cycle %0d", cycles);
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(89381));
    repeat (16) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    check(27'(status_out), 27'h34);
    for (int n = 0; n < 16; n++) issue({4'(n), 4'h7}, 1'b1);
    foreach (OPL[i]) issue(OPL[i], 1'b1);
    for (int k = 0; k < 40; k++) issue(OPL[$urandom % 38], 1'b1);
    idle();
    check(27'(exp_q.size()), 27'h0);
    check(27'(wr_cnt), 27'(exp_wr));
    check(27'(last_wr), 27'(exp_last));
    $display("decode sweep finished");
    issue(8'hDB, 1'b1);
    issue(8'h38, 1'b0);
    issue(8'h8D, 1'b0);
    idle();
    check({26'h0, phase_two_clock_held_out}, 27'h1);
    check(27'(status_out), 27'(exp_st));
    $display("stop test finished");
    @(posedge mclk_in);
    reset_n_in <= 1'b0;
    @(posedge mclk_in);
    reset_n_in <= 1'b1;
    exp_st = 8'h34;
    @(posedge mclk_in);
    #1;
    check(27'({status_out, phase_two_clock_held_out}), 27'h68);
    issue(8'h38, 1'b1);
    idle();
    check(27'(exp_q.size()), 27'h0);
    $display("restart test finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
